// ---- bench/asrp_host_model.sv ----
// host serial port model: select, read, gated host clock, chain pin.
// assumes a 125 ns host clock that stands still between frames.
`timescale 1ns/10ps
module asrp_host (
  input  wire sclk_out,                // device clock
  input  wire sclk_oe_n,               // clock enable
  input  wire frame_sync_out,          // frame strobe
  input  wire serial_result_out,       // data
  input  wire serial_result_oe_n,      // data enable
  input  wire clk_inv,                 // clock idle level
  input  wire frm_inv,                 // frame idle level
  output reg  sclk_in = 1'b0,          // host clock
  output reg  select_n = 1'b1,         // select
  output reg  read_n = 1'b1,           // read
  output reg  read_timing_or_chain_in = 1'b0 // level or chain
);
  reg [15:0] mq = 16'h0000;
  reg [7:0]  pulses = 8'h00;
  reg        last = 1'b0;
  // a released line shows the inverse of its last value
  wire       d = serial_result_oe_n ? ~last : serial_result_out;
  always @*
    if (!serial_result_oe_n)
      last = serial_result_out;
  always @(sclk_out)
    if (!sclk_oe_n && sclk_out != clk_inv) begin
      pulses = pulses + 8'h01;
      if (frame_sync_out != frm_inv)
        mq = {mq[14:0], d};
    end
  task sel(input v);
    begin
      select_n = v;
      read_n = v;
    end
  endtask
  task lvl(input v);
    read_timing_or_chain_in = v;
  endtask
  task arm;
    begin
      pulses = 8'h00;
      mq = 16'h0000;
    end
  endtask
  task xfer(input integer n, input idle, input [15:0] up, output [31:0] got);
    integer i;
    begin
      got = 32'h0000_0000;
      sclk_in = idle;
      read_timing_or_chain_in = up[15];
      #100;
      sel(1'b0);
      #100;
      for (i = 0; i < n; i = i + 1) begin
        sclk_in = 1'b0;
        if (i > 0 && i < 16)
          read_timing_or_chain_in = up[15 - i];
        #62.5;
        sclk_in = 1'b1;
        got = {got[30:0], d};
        #62.5;
      end
      // closing fall so idle-high bursts also shift the last bit
      sclk_in = 1'b0;
      #62.5;
      sclk_in = idle;
      #100;
      sel(1'b1);
    end
  endtask
endmodule

// ---- bench/asrp_properties.sv ----
// checker for the serial result port: bus handshakes, busy, data pins.
// assumes binding to asrp_serial_port; sees its ports only.
`timescale 1ns/10ps
module asrp_props #(parameter CONV_CYCLES = 40) (
  input wire aclk,                 // clock
  input wire aresetn,              // reset, low active
  input wire s_axi_awvalid,        // aw valid
  input wire s_axi_wvalid,         // w valid
  input wire s_axi_awready,        // aw ready
  input wire s_axi_bvalid,         // b valid
  input wire s_axi_bready,         // b ready
  input wire s_axi_arvalid,        // ar valid
  input wire s_axi_arready,        // ar ready
  input wire s_axi_rvalid,         // r valid
  input wire s_axi_rready,         // r ready
  input wire conversion_start_n,   // start pin
  input wire select_n,             // select pin
  input wire read_n,               // read pin
  input wire sclk_out,             // made clock
  input wire sclk_oe_n,            // clock enable
  input wire serial_result_out,    // data
  input wire serial_result_oe_n,   // data enable
  input wire busy,                 // busy
  input wire incomplete_read_flag  // error pulse
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reg [15:0] bc;
  always @(posedge aclk)
    if (!aresetn)
      bc <= 16'h0000;
    else
      bc <= busy ? bc + 16'h0001 : 16'h0000;
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_err_once;
    (incomplete_read_flag && !busy) ##1 !incomplete_read_flag;
  endsequence
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  a_write_answer: assert property (s_wr_taken |=> s_axi_bvalid)
    else $error("no write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read data");
  a_data_released: assert property ((select_n || read_n)[*4] |-> serial_result_oe_n)
    else $error("data pin driven while deselected");
  a_start_busy: assert property ($fell(conversion_start_n) |-> ##[1:6] busy)
    else $error("start did not raise busy");
  a_busy_length: assert property ($fell(busy) |-> bc >= CONV_CYCLES)
    else $error("busy too short");
  a_err_pulse: assert property (incomplete_read_flag |-> s_err_once)
    else $error("error pulse malformed");
  a_data_steady: assert property ($changed(sclk_out) && !sclk_oe_n && !$past(sclk_oe_n) |-> $stable(serial_result_out))
    else $error("data moved on clock edge");
endmodule
bind asrp_serial_port asrp_props #(.CONV_CYCLES(CONV_CYCLES)) i_asrp_props (
  .aclk                 (aclk),
  .aresetn              (aresetn),
  .s_axi_awvalid        (s_axi_awvalid),
  .s_axi_wvalid         (s_axi_wvalid),
  .s_axi_awready        (s_axi_awready),
  .s_axi_bvalid         (s_axi_bvalid),
  .s_axi_bready         (s_axi_bready),
  .s_axi_arvalid        (s_axi_arvalid),
  .s_axi_arready        (s_axi_arready),
  .s_axi_rvalid         (s_axi_rvalid),
  .s_axi_rready         (s_axi_rready),
  .conversion_start_n   (conversion_start_n),
  .select_n             (select_n),
  .read_n               (read_n),
  .sclk_out             (sclk_out),
  .sclk_oe_n            (sclk_oe_n),
  .serial_result_out    (serial_result_out),
  .serial_result_oe_n   (serial_result_oe_n),
  .busy                 (busy),
  .incomplete_read_flag (incomplete_read_flag)
);

// ---- bench/tb_adc_serial_result_port.sv ----
// bench for the serial result port: registers, master and slave reads.
// assumes the host model asrp_host and the bound checker asrp_props.
`timescale 1ns/10ps
module tb_adc_serial_result_port;
  localparam CONV = 1000;
  localparam BITC = 128;
  reg         aclk = 1'b0, aresetn = 1'b0, clk_inv = 1'b0, frm_inv = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg  [31:0] s_axi_wdata = 32'h0000_0000;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, conversion_start_n = 1'b1;
  reg  [15:0] conv_result = 16'h0000, seed, prv, up, bc = 0, bw = 0, fc = 0, fw = 0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire        select_n, read_n, read_timing_or_chain_in, sclk_in, sclk_out, sclk_oe_n;
  wire        frame_sync_out, serial_result_out, serial_result_oe_n, busy, incomplete_read_flag;
  integer     n_errors = 0, compares = 0, cyc = 0, n_flag = 0, m;
  reg  [33:0] exp_q[$];
  reg  [31:0] got;
  asrp_serial_port #(.CONV_CYCLES(CONV), .SCLK_PHASE(2)) i_asrp_serial_port (.*);
  asrp_host i_asrp_host (.*);
  always #2.5 aclk = ~aclk;
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task chk(input string nm, input [33:0] e, input [33:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("Error %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // --------------------------------------------------------------------
  // result monitor, busy and frame widths, watchdog
  // --------------------------------------------------------------------
  // watchdog: the whole run needs well under 10000 cycles
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      stop_test;
    end
  end
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", exp_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", exp_q.pop_front(), {s_axi_bresp, 32'h0000_0000});
    if (incomplete_read_flag)
      n_flag <= n_flag + 1;
    bc <= busy ? bc + 1 : 0;
    if (!busy && bc)
      bw <= bc;
    fc <= (frame_sync_out ^ frm_inv) ? fc + 1 : 0;
    if (!(frame_sync_out ^ frm_inv) && fc)
      fw <= fc;
  end
  task wr(input [7:0] a, input [31:0] d, input [1:0] e);
    begin
      @(posedge aclk);
      exp_q.push_back({e, 32'h0000_0000});
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_awready) @(posedge aclk);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [33:0] e);
    begin
      @(posedge aclk);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(posedge aclk);
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1'b0;
    end
  endtask
  task conv;
    begin
      prv = seed;
      seed = lfsr(seed);
      @(posedge aclk);
      conv_result <= seed;
      conversion_start_n <= 1'b0;
      @(posedge aclk);
      while (!busy) @(posedge aclk);
      conversion_start_n <= 1'b1;
    end
  endtask
  task idle;
    begin
      @(posedge aclk);
      while (busy) @(posedge aclk);
      repeat (4) @(posedge aclk);
    end
  endtask
  initial begin
    seed = 16'h004a;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(8'h00, {2'h0, 32'h0000_0000});
    rd(8'h0c, {2'h2, 32'h0000_0000});
    i_asrp_host.sel(1'b0);
    repeat (8) @(posedge aclk);
    chk("oe_n parallel", 1, serial_result_oe_n);
    for (m = 0; m < 2; m = m + 1) begin
      clk_inv <= m;
      frm_inv <= m;
      wr(8'h00, m ? 32'h0000_000d : 32'h0000_0001, 2'h0);
      chk("oe_n serial", 0, serial_result_oe_n);
      chk("clk oe_n master", 0, sclk_oe_n);
      i_asrp_host.lvl(m);
      i_asrp_host.arm;
      conv;
      idle;
      chk("master data", m ? prv : seed, i_asrp_host.mq);
      chk("pulses", 16, i_asrp_host.pulses);
      chk("frame width", BITC, fw);
      chk("busy width", 1, m ? bw == CONV : bw >= CONV + BITC);
    end
    wr(8'h00, 32'h0000_0003, 2'h0);
    chk("clk oe_n slave", 1, sclk_oe_n);
    i_asrp_host.sel(1'b1);
    conv;
    idle;
    up = lfsr(~seed);
    i_asrp_host.xfer(32, 1'b0, up, got);
    chk("chain read", {seed, up}, got);
    conv;
    i_asrp_host.xfer(16, 1'b1, 16'hffff, got);
    idle;
    chk("during read", prv, got);
    chk("no error", 0, n_flag);
    conv;
    i_asrp_host.xfer(4, 1'b0, 16'h0000, got);
    idle;
    chk("error pulses", 1, n_flag);
    rd(8'h04, {2'h0, 32'h0000_0008});
    wr(8'h04, 32'h0000_0008, 2'h0);
    rd(8'h04, {2'h0, 32'h0000_0000});
    // result is read-only and unmapped writes are refused without side effects
    wr(8'h08, 32'hffff_ffff, 2'h0);
    wr(8'h10, 32'h0000_0000, 2'h2);
    rd(8'h08, {2'h0, 16'h0000, seed});
    rd(8'h00, {2'h0, 32'h0000_0003});
    repeat (4) @(posedge aclk);
    stop_test;
  end
endmodule

// ---- hdl/asrp_defs.vh ----
// constants for the serial result port of the converter: register map,
// field positions, reset values and timing figures.
// assumes a 200 MHz register clock; included by asrp_serial_port.v only.
`ifndef ASRP_DEFS_VH
`define ASRP_DEFS_VH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define ASRP_CLK_PERIOD_NS   5
`define ASRP_CONV_TIME_NS    8000
`define ASRP_SCLK_PHASE_NS   10
`define ASRP_RESULT_BITS     16
`define ASRP_LAST_BIT        4'hF

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define ASRP_ADDR_CTRL       8'h00
`define ASRP_ADDR_STATUS     8'h04
`define ASRP_ADDR_RESULT     8'h08

// ----------------------------------------------------------------------------
// control fields and reset value
// ----------------------------------------------------------------------------
`define ASRP_CTRL_IFACE      0
`define ASRP_CTRL_CLKSRC     1
`define ASRP_CTRL_CLKINV     2
`define ASRP_CTRL_FRMINV     3
`define ASRP_CTRL_RESET      4'h0

// ----------------------------------------------------------------------------
// status fields
// ----------------------------------------------------------------------------
`define ASRP_STAT_BUSY       0
`define ASRP_STAT_CONV       1
`define ASRP_STAT_XFER       2
`define ASRP_STAT_ERR        3

// ----------------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------------
`define ASRP_RESP_OKAY       2'h0
`define ASRP_RESP_SLVERR     2'h2

`endif

// ---- hdl/asrp_serial_port.v ----
// serial result port of a 16-bit converter: conversion timer, master and
// slave shifters, daisy chain and incomplete-read detection, AXI4-Lite regs.
// assumes pins arrive asynchronous to aclk and the converter core result
// (conv_result) is valid on aclk.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "asrp_defs.vh"

module asrp_serial_port #(
  parameter CONV_CYCLES = `ASRP_CONV_TIME_NS / `ASRP_CLK_PERIOD_NS,
  parameter SCLK_PHASE  = `ASRP_SCLK_PHASE_NS / `ASRP_CLK_PERIOD_NS
) (
  input  wire        aclk,                    // register and logic clock
  input  wire        aresetn,                 // synchronous reset, low active
  input  wire [7:0]  s_axi_awaddr,            // write address
  input  wire        s_axi_awvalid,           // write address valid
  output wire        s_axi_awready,           // write address ready
  input  wire [31:0] s_axi_wdata,             // write data
  input  wire [3:0]  s_axi_wstrb,             // write byte strobes
  input  wire        s_axi_wvalid,            // write data valid
  output wire        s_axi_wready,            // write data ready
  output reg  [1:0]  s_axi_bresp,             // write response
  output reg         s_axi_bvalid,            // write response valid
  input  wire        s_axi_bready,            // write response ready
  input  wire [7:0]  s_axi_araddr,            // read address
  input  wire        s_axi_arvalid,           // read address valid
  output wire        s_axi_arready,           // read address ready
  output reg  [31:0] s_axi_rdata,             // read data
  output reg  [1:0]  s_axi_rresp,             // read response
  output reg         s_axi_rvalid,            // read data valid
  input  wire        s_axi_rready,            // read data ready
  input  wire [15:0] conv_result,             // converter core result
  input  wire        conversion_start_n,      // start strobe pin
  input  wire        select_n,                // device select pin
  input  wire        read_n,                  // read strobe pin
  input  wire        read_timing_or_chain_in, // read timing level or chain data
  input  wire        sclk_in,                 // host serial clock pin
  output reg         sclk_out,                // generated serial clock
  output wire        sclk_oe_n,               // clock pin enable, low drives
  output reg         frame_sync_out,          // frame-valid strobe
  output reg         serial_result_out,       // serial data
  output wire        serial_result_oe_n,      // data pin enable, low drives
  output wire        busy,                    // conversion or master read after conversion
  output reg         incomplete_read_flag     // one-cycle error pulse
);

  // --------------------------------------------------------------------------
  // configuration
  // --------------------------------------------------------------------------
  reg  [3:0]  ctrl;
  wire        interface_select      = ctrl[`ASRP_CTRL_IFACE];
  wire        clock_source_select   = ctrl[`ASRP_CTRL_CLKSRC];
  wire        clock_polarity_invert = ctrl[`ASRP_CTRL_CLKINV];
  wire        frame_polarity_invert = ctrl[`ASRP_CTRL_FRMINV];
  wire        master_mode = interface_select & ~clock_source_select;
  wire        slave_mode  = interface_select &  clock_source_select;

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  reg  [4:0]  sync_a;
  reg  [4:0]  sync_b;
  reg         sclk_q;
  reg         start_q;
  wire        start_lvl = sync_b[0];
  wire        sclk_lvl  = sync_b[1];
  wire        chain_lvl = sync_b[2];
  wire        sel_lvl   = ~sync_b[3] & ~sync_b[4];

  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_a  <= 5'h19;
      sync_b  <= 5'h19;
      sclk_q  <= 1'b0;
      start_q <= 1'b1;
    end else begin
      sync_a  <= {read_n, select_n, read_timing_or_chain_in, sclk_in, conversion_start_n};
      sync_b  <= sync_a;
      sclk_q  <= sclk_lvl;
      start_q <= start_lvl;
    end
  end

  wire        sclk_rise = sclk_lvl & ~sclk_q;
  wire        sclk_fall = ~sclk_lvl & sclk_q;

  // --------------------------------------------------------------------------
  // conversion timer
  // --------------------------------------------------------------------------
  reg         conv_active;
  reg  [31:0] conv_cnt;
  reg  [15:0] result;
  reg         m_act;
  reg         m_rac;
  wire        conv_start = ~start_lvl & start_q & ~conv_active & ~(m_act & m_rac);
  wire        conv_end   = conv_active & (conv_cnt == 32'h0000_0000);

  always @(posedge aclk) begin
    if (!aresetn) begin
      conv_active <= 1'b0;
      conv_cnt    <= 32'h0000_0000;
      result      <= 16'h0000;
    end else if (conv_start) begin
      conv_active <= 1'b1;
      conv_cnt    <= CONV_CYCLES - 1;
    end else if (conv_end) begin
      conv_active <= 1'b0;
      result      <= conv_result;
    end else if (conv_active) begin
      conv_cnt    <= conv_cnt - 32'h0000_0001;
    end
  end

  // --------------------------------------------------------------------------
  // master engine: four phases per bit, data moves only in phase 0
  // --------------------------------------------------------------------------
  reg  [1:0]  m_ph;
  reg  [31:0] m_sub;
  reg  [3:0]  m_bit;
  wire        m_tick  = m_act & (m_sub == SCLK_PHASE - 1);
  wire        m_load  = master_mode & (chain_lvl ? conv_start : conv_end);
  wire        m_shift = m_tick & (m_ph == 2'h3) & (m_bit != `ASRP_LAST_BIT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      m_act <= 1'b0;
      m_rac <= 1'b0;
      m_ph  <= 2'h0;
      m_sub <= 32'h0000_0000;
      m_bit <= 4'h0;
    end else if (m_load) begin
      m_act <= 1'b1;
      m_rac <= ~chain_lvl;
      m_ph  <= 2'h0;
      m_sub <= 32'h0000_0000;
      m_bit <= 4'h0;
    end else if (m_act) begin
      m_sub <= m_tick ? 32'h0000_0000 : m_sub + 32'h0000_0001;
      if (m_tick) begin
        m_ph <= m_ph + 2'h1;
        if (m_ph == 2'h3) begin
          if (m_bit == `ASRP_LAST_BIT)
            m_act <= 1'b0;
          else
            m_bit <= m_bit + 4'h1;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sclk_out       <= 1'b0;
      frame_sync_out <= 1'b0;
    end else begin
      sclk_out       <= (m_act & (m_ph == 2'h1)) ^ clock_polarity_invert;
      frame_sync_out <= m_act ^ frame_polarity_invert;
    end
  end

  assign sclk_oe_n = ~master_mode;
  assign busy      = conv_active | (m_act & m_rac);

  // --------------------------------------------------------------------------
  // shift register shared by both modes, slave clocked by host edges
  // --------------------------------------------------------------------------
  reg  [15:0] shreg;
  reg  [4:0]  s_cnt;
  reg         s_rose;
  reg         chain_bit;
  reg         rd_seen;
  wire        s_reload = slave_mode & (conv_start | conv_end);
  wire        s_shift  = slave_mode & sel_lvl & sclk_fall & s_rose;

  always @(posedge aclk) begin
    if (!aresetn) begin
      shreg     <= 16'h0000;
      s_cnt     <= 5'h00;
      s_rose    <= 1'b0;
      chain_bit <= 1'b0;
    end else if (m_load) begin
      shreg     <= chain_lvl ? result : conv_result;
    end else if (m_shift) begin
      shreg     <= {shreg[14:0], 1'b0};
    end else if (s_reload) begin
      // new result after conversion, previous result during the next one
      shreg     <= conv_end ? conv_result : result;
      s_cnt     <= 5'h00;
      s_rose    <= 1'b0;
    end else if (slave_mode & sel_lvl & sclk_rise) begin
      s_rose    <= 1'b1;
      chain_bit <= chain_lvl & ~conv_active;
    end else if (s_shift) begin
      shreg     <= {shreg[14:0], chain_bit};
      if (s_cnt != `ASRP_RESULT_BITS)
        s_cnt   <= s_cnt + 5'h01;
    end
  end

  // output register: changes only right after a falling edge, in phase 0, or on a slave reload at conversion start or end
  always @(posedge aclk) begin
    if (!aresetn)
      serial_result_out <= 1'b0;
    else
      serial_result_out <= shreg[15];
  end

  assign serial_result_oe_n = ~(interface_select & sel_lvl);

  // --------------------------------------------------------------------------
  // incomplete read during conversion
  // --------------------------------------------------------------------------
  reg         err_sticky;
  reg         err_clr;

  always @(posedge aclk) begin
    if (!aresetn) begin
      rd_seen              <= 1'b0;
      incomplete_read_flag <= 1'b0;
    end else begin
      incomplete_read_flag <= slave_mode & conv_end & rd_seen
                              & (s_cnt != `ASRP_RESULT_BITS);
      if (conv_start | ~slave_mode)
        rd_seen <= 1'b0;
      else if (conv_active & sel_lvl)
        rd_seen <= 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn)
      err_sticky <= 1'b0;
    else if (incomplete_read_flag)
      err_sticky <= 1'b1;  // a new error wins over a clear in the same cycle
    else if (err_clr)
      err_sticky <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite slave: takes address and data together, one at a time
  // --------------------------------------------------------------------------
  wire        wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  wire        rd_go = s_axi_arvalid & ~s_axi_rvalid;

  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl         <= `ASRP_CTRL_RESET;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ASRP_RESP_OKAY;
      err_clr      <= 1'b0;
    end else begin
      err_clr <= 1'b0;
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `ASRP_RESP_OKAY;
        if (s_axi_awaddr == `ASRP_ADDR_CTRL) begin
          if (s_axi_wstrb[0])
            ctrl <= s_axi_wdata[3:0];
        end else if (s_axi_awaddr == `ASRP_ADDR_STATUS) begin
          if (s_axi_wstrb[0])
            err_clr <= s_axi_wdata[`ASRP_STAT_ERR];
        end else if (s_axi_awaddr != `ASRP_ADDR_RESULT) begin
          s_axi_bresp <= `ASRP_RESP_SLVERR;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `ASRP_RESP_OKAY;
    end else begin
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `ASRP_RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == `ASRP_ADDR_CTRL)
          s_axi_rdata[3:0] <= ctrl;
        else if (s_axi_araddr == `ASRP_ADDR_STATUS)
          s_axi_rdata[3:0] <= {err_sticky, m_act, conv_active, busy};
        else if (s_axi_araddr == `ASRP_ADDR_RESULT)
          s_axi_rdata[15:0] <= result;
        else
          s_axi_rresp <= `ASRP_RESP_SLVERR;
      end
    end
  end

endmodule
